// ===== shared/mute_select_pkg.sv
// Purpose: Constants for the audio port mute source select block.
// Assumes: APB with 32-bit data; registers at the printed byte addresses.
// Notes: All 32 address bits are decoded for each register address.
package mute_select_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SEL_W = 3;
  localparam int SRC_N = 8;
  localparam logic [ADDR_W-1:0] PORT1_MUTE_SRC_ADDR = 32'h4000001C;
  localparam logic [ADDR_W-1:0] PORT2_MUTE_SRC_ADDR = 32'h40000020;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 2;
  localparam logic [DATA_W-1:0] RSVD_READ = 32'h00000000;
  localparam logic [SEL_W-1:0] CODE_ZERO = 3'h0;
  localparam logic [SEL_W-1:0] CODE_SECOND_SPI_CLOCK_PIN = 3'h1;
  localparam logic [SEL_W-1:0] CODE_SECOND_SPI_SLAVE_OUT_PIN = 3'h2;
  localparam logic [SEL_W-1:0] CODE_SECOND_SPI_SLAVE_IN_PIN = 3'h3;
  localparam logic [SEL_W-1:0] CODE_P2_HCLK = 3'h4;
  localparam logic [SEL_W-1:0] CODE_FIRST_SPI_SLAVE_IN_PIN = 3'h5;
  localparam logic [SEL_W-1:0] CODE_SPI0_CS = 3'h6;
  localparam logic [SEL_W-1:0] CODE_FIRST_SPI_ENABLE_PIN = 3'h7;
endpackage

// ===== logic/mute_source_mux.sv
// Purpose: Eight-to-one combinational selector for one mute input.
// Assumes: Source vector index equals the select code.
// Notes: Index zero is tied low by the caller.
`timescale 1ns/10ps
module mute_source_mux #(
  parameter int SEL_W = mute_select_pkg::SEL_W,
  parameter int SRC_N = mute_select_pkg::SRC_N
) (
  input wire logic [SEL_W-1:0] sel, // Registered select code
  input wire logic [SRC_N-1:0] src, // Candidate sources
  output wire logic mute_out // Chosen source
);
  assign mute_out = src[sel];
endmodule

// ===== logic/mute_select_reg.sv
// Purpose: One three-bit select register written over APB.
// Assumes: Write strobe is a completed APB write to this register.
// Notes: Reserved bits are not stored.
`timescale 1ns/10ps
module mute_select_reg #(
  parameter int SEL_W = mute_select_pkg::SEL_W
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic wr, // Write strobe
  input wire logic [SEL_W-1:0] wdata, // New select code
  output logic [SEL_W-1:0] sel_q // Stored select code
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_q <= mute_select_pkg::SEL_RESET;
    else if (wr)
      sel_q <= wdata;
  end
endmodule

// ===== logic/audio_port_mute_source_select.sv
// Purpose: Routes one of eight sources to the mute inputs of audio ports 1 and 2.
// Assumes: Pin inputs are synchronous to pclk.
// Notes: Reads of bits 31 to 3 return zero.
//
// Overview of operation
// - Port 1 three-bit select, resets zero.
// - Port 2 identical select, resets zero.
// - Code 000 drives constant zero.
// - Codes 001-011 route the second SPI pins.
// - Codes 100,101 route high-rate clock, SPI0 in.
// - Codes 110,111 route shared SPI0/I2C pins.
// - Bits 31:3 reserved, read as zero.
// - Reduced variant: port 2 register is inert.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module audio_port_mute_source_select #(
  parameter bit HAS_PORT2 = 1'b1
) (
  input wire logic pclk, // Bus clock, 10 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [mute_select_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [mute_select_pkg::DATA_W-1:0] pwdata, // APB write data
  output logic [mute_select_pkg::DATA_W-1:0] prdata, // APB read data
  output wire logic pready, // APB ready
  output wire logic pslverr, // APB error
  input wire logic second_spi_clock_pin, // Port 0 data 7 / SPI1 clock
  input wire logic second_spi_slave_out_pin, // Port 0 data 8 / port 1 data 5
  input wire logic second_spi_slave_in_pin, // Port 0 data 9 / port 1 data 4
  input wire logic port2_receive_high_rate_clock_pin, // Port 2 receive clock
  input wire logic first_spi_slave_in_pin, // SPI0 slave in
  input wire logic first_spi_chip_select_pin, // SPI0 chip select / I2C1 clock
  input wire logic first_spi_enable_pin, // SPI0 enable / I2C1 data
  output wire logic port1_mute_in, // Port 1 mute input
  output wire logic port2_mute_in // Port 2 mute input
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic hit1;
  wire logic hit2;
  wire logic acc;
  wire logic wr1;
  wire logic wr2;
  wire logic [mute_select_pkg::SEL_W-1:0] wsel;
  wire logic [mute_select_pkg::SEL_W-1:0] port1_mute_select_field;
  wire logic [mute_select_pkg::SEL_W-1:0] port2_mute_select_field;
  wire logic [mute_select_pkg::SRC_N-1:0] src;

  assign hit1 = paddr == mute_select_pkg::PORT1_MUTE_SRC_ADDR;
  assign hit2 = (paddr == mute_select_pkg::PORT2_MUTE_SRC_ADDR) && HAS_PORT2;
  assign acc = psel && penable;
  assign wr1 = acc && pwrite && hit1;
  assign wr2 = acc && pwrite && hit2;
  assign wsel = pwdata[mute_select_pkg::SEL_MSB:mute_select_pkg::SEL_LSB];
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Unmapped and reserved reads return zero.
  always_comb
  begin
    prdata = mute_select_pkg::RSVD_READ;
    if (hit1)
      prdata[mute_select_pkg::SEL_MSB:mute_select_pkg::SEL_LSB] = port1_mute_select_field;
    else if (hit2)
      prdata[mute_select_pkg::SEL_MSB:mute_select_pkg::SEL_LSB] = port2_mute_select_field;
  end

  // ----------------------------------------------------------------
  // Select registers
  // ----------------------------------------------------------------
  mute_select_reg u_reg1 (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr1),
    .wdata(wsel),
    .sel_q(port1_mute_select_field)
  );

  mute_select_reg u_reg2 (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr2),
    .wdata(wsel),
    .sel_q(port2_mute_select_field)
  );

  // ----------------------------------------------------------------
  // Source routing
  // ----------------------------------------------------------------
  assign src[mute_select_pkg::CODE_ZERO] = 1'b0;
  assign src[mute_select_pkg::CODE_SECOND_SPI_CLOCK_PIN] = second_spi_clock_pin;
  assign src[mute_select_pkg::CODE_SECOND_SPI_SLAVE_OUT_PIN] = second_spi_slave_out_pin;
  assign src[mute_select_pkg::CODE_SECOND_SPI_SLAVE_IN_PIN] = second_spi_slave_in_pin;
  assign src[mute_select_pkg::CODE_P2_HCLK] = port2_receive_high_rate_clock_pin;
  assign src[mute_select_pkg::CODE_FIRST_SPI_SLAVE_IN_PIN] = first_spi_slave_in_pin;
  assign src[mute_select_pkg::CODE_SPI0_CS] = first_spi_chip_select_pin;
  assign src[mute_select_pkg::CODE_FIRST_SPI_ENABLE_PIN] = first_spi_enable_pin;

  mute_source_mux u_mux1 (
    .sel(port1_mute_select_field),
    .src(src),
    .mute_out(port1_mute_in)
  );

  mute_source_mux u_mux2 (
    .sel(port2_mute_select_field),
    .src(src),
    .mute_out(port2_mute_in)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wr1;
    acc && pwrite && hit1;
  endsequence

  AST_P1_RESET: assert property (@(posedge pclk) $rose(presetn) |-> port1_mute_select_field == 3'h0) else $error("port 1 select not zero after reset");
  AST_P1_WRITE: assert property (@(posedge pclk) disable iff (!presetn) s_wr1 |=> port1_mute_select_field == $past(pwdata[2:0])) else $error("port 1 write not stored");
  AST_P2_WRITE: assert property (@(posedge pclk) disable iff (!presetn) wr2 |=> port2_mute_select_field == $past(pwdata[2:0])) else $error("port 2 write not stored");
  AST_P1_HOLD: assert property (@(posedge pclk) disable iff (!presetn) !wr1 |=> $stable(port1_mute_select_field)) else $error("port 1 select changed without write");
  AST_ZERO: assert property (@(posedge pclk) disable iff (!presetn) port1_mute_select_field == 3'h0 |-> !port1_mute_in) else $error("code zero not low");
  AST_SPI1: assert property (@(posedge pclk) disable iff (!presetn) port1_mute_select_field == 3'h2 |-> port1_mute_in == second_spi_slave_out_pin) else $error("code two misrouted");
  AST_HCLK: assert property (@(posedge pclk) disable iff (!presetn) port2_mute_select_field == 3'h4 |-> port2_mute_in == port2_receive_high_rate_clock_pin) else $error("code four misrouted");
  AST_SHARED: assert property (@(posedge pclk) disable iff (!presetn) port1_mute_select_field == 3'h7 |-> port1_mute_in == first_spi_enable_pin) else $error("code seven misrouted");
  AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn) acc && !pwrite |-> prdata[31:3] == 29'h0) else $error("reserved bits not zero");
  AST_VARIANT: assert property (@(posedge pclk) disable iff (!presetn) !HAS_PORT2 |-> port2_mute_select_field == 3'h0) else $error("port 2 register active on reduced variant");

endmodule

// ===== tb/tb_audio_port_mute_source_select.sv
// Purpose: Self-checking bench for the audio port mute source select block.
// Assumes: Zero-wait APB slave; pin inputs are plain levels.
// Notes: A second instance checks the reduced variant without port 2.
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("Error %0t: value mismatch", $time); end end
module tb_audio_port_mute_source_select;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] pins = 7'h00;
  logic [1:0] mute;
  logic [31:0] prdata_r;
  logic [1:0] mute_r;
  logic [31:0] rd;
  int err_total = 0;
  int total_checks = 0;
  always #50 pclk = ~pclk;
  audio_port_mute_source_select DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .second_spi_clock_pin(pins[0]),
    .second_spi_slave_out_pin(pins[1]), .second_spi_slave_in_pin(pins[2]),
    .port2_receive_high_rate_clock_pin(pins[3]), .first_spi_slave_in_pin(pins[4]),
    .first_spi_chip_select_pin(pins[5]), .first_spi_enable_pin(pins[6]),
    .port1_mute_in(mute[0]), .port2_mute_in(mute[1]));
  audio_port_mute_source_select #(.HAS_PORT2(1'b0)) DUT_REDUCED (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_r), .pready(), .pslverr(),
    .second_spi_clock_pin(pins[0]), .second_spi_slave_out_pin(pins[1]),
    .second_spi_slave_in_pin(pins[2]), .port2_receive_high_rate_clock_pin(pins[3]),
    .first_spi_slave_in_pin(pins[4]), .first_spi_chip_select_pin(pins[5]),
    .first_spi_enable_pin(pins[6]), .port1_mute_in(mute_r[0]), .port2_mute_in(mute_r[1]));
  // ----------------------------------------
  // Bus cycles and closing
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    `CHK(mute, 2'h0)
    apb(1'b0, mute_select_pkg::PORT1_MUTE_SRC_ADDR, 32'h00000000);
    `CHK(rd[2:0], 3'h0)
    apb(1'b0, mute_select_pkg::PORT2_MUTE_SRC_ADDR, 32'h00000000);
    `CHK(rd[2:0], 3'h0)
    $display("test_reset done");
  endtask
  task automatic test_codes();
    logic [6:0] hot;
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 8; c++)
      begin
        hot = (c == 0) ? 7'h7F : (7'h01 << (c - 1));
        apb(1'b1, (p == 0) ? 32'h4000001C : 32'h40000020, c);
        apb(1'b0, (p == 0) ? 32'h4000001C : 32'h40000020, 32'h00000000);
        `CHK(rd, c)
        pins <= hot;
        @(negedge pclk);
        `CHK(mute[p], (c != 0))
        @(posedge pclk);
        pins <= ~hot;
        @(negedge pclk);
        `CHK(mute[p], 1'b0)
      end
    $display("test_codes done");
  endtask
  task automatic test_reserved();
    apb(1'b1, 32'h4000001C, 32'hFFFFFFFD);
    apb(1'b0, 32'h4000001C, 32'h00000000);
    `CHK(rd, 32'h00000005)
    apb(1'b1, 32'h40000024, 32'h00000002);
    `CHK(pslverr, 1'b0)
    apb(1'b0, 32'h40000024, 32'h00000000);
    `CHK(rd, 32'h00000000)
    apb(1'b0, 32'h4000001C, 32'h00000000);
    `CHK(rd, 32'h00000005)
    apb(1'b0, 32'h40000020, 32'h00000000);
    `CHK(rd, 32'h00000007)
    $display("test_reserved done");
  endtask
  task automatic test_variant();
    apb(1'b1, 32'h40000020, 32'h00000004);
    apb(1'b0, 32'h40000020, 32'h00000000);
    `CHK(rd, 32'h00000004)
    `CHK(prdata_r, 32'h00000000)
    pins <= 7'h7F;
    @(negedge pclk);
    `CHK(mute[1], 1'b1)
    `CHK(mute_r[1], 1'b0)
    `CHK(mute_r[0], 1'b1)
    @(posedge pclk);
    pins <= 7'h00;
    $display("test_variant done");
  endtask
  initial
  begin
    #300000;
    err_total++;
    wrap_up();
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_codes();
    test_reserved();
    test_variant();
    wrap_up();
  end
endmodule
